// File: dv/gfiu_pad_model.sv
/*
  Board model of the three pads: drive, pulls and a floating wire.
  Assumes pad controls straight from the unit.
*/
`timescale 1ns/10ps
module gfiu_pad_model
  import gfiu_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic [NUM_PINS-1:0] drv_in,
  input  wire logic [NUM_PINS-1:0] oe_in,
  input  wire logic [NUM_PINS-1:0] dn_in,
  input  wire logic [NUM_PINS-1:0] up_in,
  output logic      [NUM_PINS-1:0] level_out
);
  logic [NUM_PINS-1:0] last = 3'h0;
  // A floating pad toggles each cycle so a stale level never reads as a match
  assign level_out = (oe_in & drv_in) | (~oe_in & (up_in | (~dn_in & ~last)));
  always @(posedge clk_in) last <= level_out;
endmodule

// File: dv/gfiu_sva.sv
/*
  Checker for the pin unit register and pad control ports.
  Assumes a bind from the bench top, one clock domain.
*/
`timescale 1ns/10ps
module gfiu_sva
  import gfiu_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire gfiu_reg_req_s       reg_req_in,
  input  wire logic [7:0]          reg_rdata_out,
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic [NUM_PINS-1:0] pin_oe_out,
  input  wire logic [NUM_PINS-1:0] pin_slow_slew_out,
  input  wire logic [NUM_PINS-1:0] pin_pulldown_out,
  input  wire logic [NUM_PINS-1:0] pin_pullup_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire w1 = reg_req_in.write && reg_req_in.addr == ADDR_PIN_ONE;
  wire w2 = reg_req_in.write && reg_req_in.addr == ADDR_PIN_TWO;
  wire w3 = reg_req_in.write && reg_req_in.addr == ADDR_PIN_THREE;
  wire rl = reg_req_in.read && reg_req_in.addr == ADDR_PIN_LEVEL;
  a_rdata_hold: assert property (!reg_req_in.read |=> $stable(reg_rdata_out)) else $error("rdata moved");
  a_pull_excl: assert property ((pin_pulldown_out & pin_pullup_out) == 3'h0) else $error("two pulls");
  // Code 11 is unused and must drive neither pull, so compare whole field codes
  a_pull_cfg: assert property (w1 |-> ##2 pin_pulldown_out[0] == ($past(reg_req_in.wdata[4:3], 2) == PULL_DOWN) &&
    pin_pullup_out[0] == ($past(reg_req_in.wdata[4:3], 2) == PULL_UP)) else $error("pull control wrong");
  a_slew_cfg: assert property (w2 |-> ##2 pin_slow_slew_out[1] == $past(reg_req_in.wdata[FLD_SLEW], 2))
    else $error("slew control wrong");
  a_input_float: assert property (w3 && reg_req_in.wdata[1:0] == MODE_INPUT |-> ##2 !pin_oe_out[2])
    else $error("input pin driven");
  a_level_read: assert property (rl |=> reg_rdata_out == {5'h00, $past(pin_in)}) else $error("level wrong");
  a_nomap_zero: assert property (reg_req_in.read && reg_req_in.addr > ADDR_PIN_LEVELS |=> reg_rdata_out == 8'h00)
    else $error("unmapped read");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> pin_oe_out == 3'h0) else $error("drive after reset");
endmodule

// File: dv/tb_top.sv
/*
  Bench top: register tasks, pad table, wave timing and interrupt flags.
  Assumes the unit, its checker and the pad model.
*/
`timescale 1ns/10ps
module tb_top;
  import gfiu_pkg::*;
  localparam int T = TICK_CYCLES + 1;
  logic                clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  gfiu_reg_req_s       req = '0;
  gfiu_events_s        ev = 7'h04;
  logic [7:0]          rdata;
  logic [NUM_PINS-1:0] lvl, p_out, p_oe, p_slew, p_dn, p_up;
  int                  errors = 0, n_checks = 0, cyc = 0;
  always #2 clk_in = ~clk_in;
  gfiu_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata), .events_in(ev),
    .pin_in(lvl), .pin_out(p_out), .pin_oe_out(p_oe), .pin_slow_slew_out(p_slew), .pin_pulldown_out(p_dn),
    .pin_pullup_out(p_up));
  gfiu_pad_model pad_u (.clk_in(clk_in), .drv_in(p_out), .oe_in(p_oe), .dn_in(p_dn), .up_in(p_up), .level_out(lvl));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
    n_checks++;
    if (act !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req <= '0;
    #1 v = rdata;
  endtask
  task automatic wait_pin(input logic v);
    while (p_out[1] !== v) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  task final_report;
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling lies far above the run, as retiming cuts the running low phase to the new 3 ticks
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    logic [15:0] rv [7] = '{16'h1a00, 16'h1b00, 16'h1c00, 16'h1ffe, 16'h2200, 16'h2364, 16'h3000};
    logic [13:0] rows [6] = '{14'h0071, 14'h0870, 14'h04a3, 14'h0294, 14'h01f9, 14'h04c3};
    logic [7:0]  fm [7] = '{8'h80, 8'h20, 8'h50, 8'h08, 8'h04, 8'h02, 8'h01};
    logic [7:0]  got;
    int          t_hi, t_lo, mm;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(rv[i][15:8], got);
      chk("reset_value", {8'h00, rv[i][7:0]}, {8'h00, got});
    end
    wr(ADDR_WAVE_HIGH, 8'h01);
    wr(ADDR_WAVE_LOW, 8'h02);
    wr(ADDR_PIN_TWO, 8'h41);
    wr(ADDR_PIN_THREE, 8'h61);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_PIN_ONE, rows[i][13:6]);
      wr(ADDR_PIN_LEVELS, {7'h00, rows[i][5]});
      rd(ADDR_PIN_LEVEL, got);
      chk("pad_ctl", {12'h000, rows[i][4:1]}, {12'h000, p_oe[0], p_slew[0], p_dn[0], p_up[0]});
      chk("pin_level", {15'h0000, rows[i][0]}, {15'h0000, got[0]});
    end
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t_hi = 0;
    t_lo = 0;
    mm = 0;
    while (p_out[1] === 1'b1) begin
      @(posedge clk_in);
      #1 t_hi++;
      mm += int'(p_out[2] === p_out[1]);
    end
    while (p_out[1] === 1'b0) begin
      @(posedge clk_in);
      #1 t_lo++;
      mm += int'(p_out[2] === p_out[1]);
    end
    chk("high_time", 16'(2 * T), 16'(t_hi));
    chk("low_time", 16'(3 * T), 16'(t_lo));
    chk("shared_wave", 16'h0000, 16'(mm));
    wr(ADDR_PIN_THREE, 8'h00);
    wr(ADDR_PIN_TWO, 8'hc1);
    rd(ADDR_IRQ_FLAGS, got);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_IRQ_ENABLE, p[0] ? 8'hff : 8'h00);
      for (int j = 0; j < 7; j++) begin
        @(posedge clk_in) ev <= ev ^ (7'h01 << j);
        repeat (3) @(posedge clk_in);
        #1 chk("irq_pin", {15'h0000, p[0]}, {15'h0000, p_out[1]});
        rd(ADDR_IRQ_FLAGS, got);
        chk("flags", {8'h00, p[0] ? fm[j] : 8'h00}, {8'h00, got});
        @(posedge clk_in) ev <= ev ^ (7'h01 << j);
        repeat (2) @(posedge clk_in);
        #1 chk("irq_clear", 16'h0000, {15'h0000, p_out[1]});
      end
    end
    @(posedge clk_in) begin
      req <= '{1'b0, 1'b1, ADDR_IRQ_FLAGS, 8'h00};
      ev <= ev ^ 7'h08;
    end
    @(posedge clk_in) req <= '0;
    #1 chk("flags_race", 16'h0000, {8'h00, rdata});
    rd(ADDR_IRQ_FLAGS, got);
    chk("flags_kept", 16'h0008, {8'h00, got});
    final_report();
  end
endmodule
bind gfiu_top gfiu_sva chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_oe_out(pin_oe_out), .pin_slow_slew_out(pin_slow_slew_out),
  .pin_pulldown_out(pin_pulldown_out), .pin_pullup_out(pin_pullup_out));

// File: rtl/gfiu_pkg.sv
/*
  Package for the pin configuration, wave generator and interrupt unit.
  Holds register indices, field positions, reset values and shared types.
  Assumes an 8-bit register port with indexed access from the serial interface.
*/
package gfiu_pkg;
  localparam int          NUM_PINS          = 3;
  localparam logic [7:0]  ADDR_PIN_ONE      = 8'h1a;
  localparam logic [7:0]  ADDR_PIN_TWO      = 8'h1b;
  localparam logic [7:0]  ADDR_PIN_THREE    = 8'h1c;
  localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h1f;
  localparam logic [7:0]  ADDR_IRQ_FLAGS    = 8'h20;
  localparam logic [7:0]  ADDR_PIN_LEVEL    = 8'h21;
  localparam logic [7:0]  ADDR_WAVE_HIGH    = 8'h22;
  localparam logic [7:0]  ADDR_WAVE_LOW     = 8'h23;
  localparam logic [7:0]  ADDR_PIN_LEVELS   = 8'h24;
  localparam logic [7:0]  RST_PIN_CONFIG    = 8'h00;
  localparam logic [7:0]  RST_IRQ_ENABLE    = 8'hfe;
  localparam logic [7:0]  RST_WAVE_HIGH     = 8'h00;
  localparam logic [7:0]  RST_WAVE_LOW      = 8'h64;
  localparam int          FLD_MODE_LO       = 0;
  localparam int          FLD_SLEW          = 2;
  localparam int          FLD_PULL_LO       = 3;
  localparam int          FLD_INVERT        = 5;
  localparam int          FLD_SRC_LO        = 6;
  localparam logic [1:0]  MODE_INPUT        = 2'h0;
  localparam logic [1:0]  MODE_PUSH_PULL    = 2'h1;
  localparam logic [1:0]  MODE_NMOS_ONLY    = 2'h2;
  localparam logic [1:0]  MODE_PMOS_ONLY    = 2'h3;
  localparam logic [1:0]  PULL_DOWN         = 2'h1;
  localparam logic [1:0]  PULL_UP           = 2'h2;
  localparam logic [1:0]  SRC_WAVE          = 2'h1;
  localparam logic [1:0]  SRC_IRQ           = 2'h3;
  localparam real         SYS_CLK_MHZ       = 1.1;
  localparam real         CORE_CLK_MHZ      = 250.0;
  localparam int          TICK_CYCLES       = int'(CORE_CLK_MHZ / SYS_CLK_MHZ - 0.5);

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gfiu_reg_req_s;

  typedef struct packed {
    logic watchdog_rollover;
    logic charge_off_level;
    logic thermal_alert;
    logic power_key;
    logic charger_detect;
    logic charge_restart_threshold;
    logic charger_overvolt_signal;
  } gfiu_events_s;
endpackage

// File: rtl/gfiu_top.sv
/*
  General purpose pin unit: three configurable pins, one shared wave
  generator and a latched interrupt with read-to-clear status.
  Assumes a register port driven synchronously to clk_in with one-cycle
  read/write strobes; pad cells take drive, pull and slew controls.
*/
`timescale 1ns/10ps
module gfiu_top
  import gfiu_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire gfiu_reg_req_s         reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire gfiu_events_s          events_in,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  output logic [NUM_PINS-1:0]        pin_out,
  output logic [NUM_PINS-1:0]        pin_oe_out,
  output logic [NUM_PINS-1:0]        pin_slow_slew_out,
  output logic [NUM_PINS-1:0]        pin_pulldown_out,
  output logic [NUM_PINS-1:0]        pin_pullup_out
);

  logic [7:0]          pin_config [NUM_PINS];
  logic [7:0]          irq_source_enable;
  logic [7:0]          irq_event_flags;
  logic [7:0]          wave_high_duration;
  logic [7:0]          wave_low_duration;
  logic [NUM_PINS-1:0] pin_software_level;
  logic                irq_line;
  logic [7:0]          tick_count;
  logic                tick;
  logic [7:0]          phase_count;
  logic                wave_level;
  logic [7:0]          event_prev;
  logic [7:0]          event_now;
  logic [7:0]          event_edges;
  logic                flags_read;
  logic [7:0]          next_flags;
  logic [7:0]          read_mux;
  logic [NUM_PINS-1:0] routed;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic                wr_pin_levels;

  // Event vector by bit position; detect level is inverted so a fall is a rise
  assign event_now = {events_in.charger_overvolt_signal, ~events_in.charger_detect,
                      events_in.charge_restart_threshold, ~events_in.charger_detect,
                      events_in.power_key, events_in.thermal_alert,
                      events_in.charge_off_level, events_in.watchdog_rollover};
  assign event_edges = event_now & ~event_prev & irq_source_enable;
  assign flags_read  = reg_req_in.read && (reg_req_in.addr == ADDR_IRQ_FLAGS);
  // Set wins over the read clear, so nothing is lost across the read
  assign next_flags  = (flags_read ? 8'h00 : irq_event_flags) | event_edges;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_prev      <= 8'h00;
      irq_event_flags <= 8'h00;
      irq_line        <= 1'b0;
    end else begin
      event_prev      <= event_now;
      irq_event_flags <= next_flags;
      irq_line        <= |next_flags;
    end
  end

  // Tick divider approximates the 1.1 MHz system clock from the core clock
  assign tick = (tick_count == 8'(TICK_CYCLES));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_count <= 8'h00;
    end else begin
      tick_count <= tick ? 8'h00 : tick_count + 8'h01;
    end
  end

  // Reprogramming at or above the running count takes effect at once, even mid-phase, as each tick compares against the live duration
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_count <= 8'h00;
      wave_level  <= 1'b0;
    end else if (tick) begin
      if (phase_count == (wave_level ? wave_high_duration : wave_low_duration)) begin
        phase_count <= 8'h00;
        wave_level  <= ~wave_level;
      end else begin
        phase_count <= phase_count + 8'h01;
      end
    end
  end

  assign wr_pin_levels = reg_req_in.write && (reg_req_in.addr == ADDR_PIN_LEVELS);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_source_enable  <= RST_IRQ_ENABLE;
      wave_high_duration <= RST_WAVE_HIGH;
      wave_low_duration  <= RST_WAVE_LOW;
      pin_software_level <= '0;
    end else if (reg_req_in.write) begin
      if (reg_req_in.addr == ADDR_IRQ_ENABLE) begin
        irq_source_enable <= reg_req_in.wdata;
      end
      if (reg_req_in.addr == ADDR_WAVE_HIGH) begin
        wave_high_duration <= reg_req_in.wdata;
      end
      if (reg_req_in.addr == ADDR_WAVE_LOW) begin
        wave_low_duration <= reg_req_in.wdata;
      end
      if (wr_pin_levels) begin
        pin_software_level <= reg_req_in.wdata[NUM_PINS-1:0];
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [1:0] mode;
      logic [1:0] src;
      logic [1:0] pull;
      assign mode = pin_config[p][FLD_MODE_LO +: 2];
      assign src  = pin_config[p][FLD_SRC_LO +: 2];
      assign pull = pin_config[p][FLD_PULL_LO +: 2];
      // Source 10 behaves as register level, matching the x0 encoding
      assign routed[p] = (src == SRC_IRQ)  ? irq_line :
                         (src == SRC_WAVE) ? wave_level :
                                             pin_software_level[p];
      assign next_pin_out[p] = routed[p] ^ pin_config[p][FLD_INVERT];
      // Open-drain modes only drive when the active transistor pulls
      assign next_pin_oe[p]  = (mode == MODE_PUSH_PULL) ||
                               ((mode == MODE_NMOS_ONLY) && !next_pin_out[p]) ||
                               ((mode == MODE_PMOS_ONLY) && next_pin_out[p]);

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_config[p]        <= RST_PIN_CONFIG;
          pin_out[p]           <= 1'b0;
          pin_oe_out[p]        <= 1'b0;
          pin_slow_slew_out[p] <= 1'b0;
          pin_pulldown_out[p]  <= 1'b0;
          pin_pullup_out[p]    <= 1'b0;
        end else begin
          if (reg_req_in.write && (reg_req_in.addr == ADDR_PIN_ONE + 8'(p))) begin
            pin_config[p] <= reg_req_in.wdata;
          end
          pin_out[p]           <= next_pin_out[p];
          pin_oe_out[p]        <= next_pin_oe[p];
          pin_slow_slew_out[p] <= pin_config[p][FLD_SLEW];
          pin_pulldown_out[p]  <= (pull == PULL_DOWN);
          pin_pullup_out[p]    <= (pull == PULL_UP);
        end
      end
    end
  endgenerate

  // Pad input sees the driven level, so readback equals output when driven
  always_comb begin
    unique case (reg_req_in.addr)
      ADDR_PIN_ONE:    read_mux = pin_config[0];
      ADDR_PIN_TWO:    read_mux = pin_config[1];
      ADDR_PIN_THREE:  read_mux = pin_config[2];
      ADDR_IRQ_ENABLE: read_mux = irq_source_enable;
      ADDR_IRQ_FLAGS:  read_mux = irq_event_flags;
      ADDR_PIN_LEVEL:  read_mux = {5'h00, pin_in};
      ADDR_WAVE_HIGH:  read_mux = wave_high_duration;
      ADDR_WAVE_LOW:   read_mux = wave_low_duration;
      ADDR_PIN_LEVELS: read_mux = {5'h00, pin_software_level};
      default:         read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.read) begin
      reg_rdata_out <= read_mux;
    end
  end

endmodule
